// file: flash_ctrl_regs.vh
// Register map, field positions, commands and timing of the code flash controller
`ifndef FLASH_CTRL_REGS_VH
`define FLASH_CTRL_REGS_VH

`define REG_CTRL_STATUS  8'h00
`define REG_DATA         8'h04
`define REG_ADDR_LO      8'h08
`define REG_ADDR_HI      8'h0c
`define REG_SECURITY     8'h10
`define REG_BOOT         8'h14
`define REG_CHECKSUM     8'h18
`define REG_INFO         8'h1c

`define ST_BUSY_BIT      0
`define ST_DONE_BIT      1
`define ST_IGNORED_BIT   2
`define ST_LAST_OP_LSB   4
`define CTL_CMD_LSB      0
`define CTL_DONE_CLR_BIT 8
`define CTL_IGN_CLR_BIT  9

`define CMD_NONE         4'h0
`define CMD_COMMIT       4'h1
`define CMD_ERASE_BYTE   4'h2
`define CMD_ERASE_PAGE   4'h3
`define CMD_ERASE_SECTOR 4'h4
`define CMD_ERASE_CHIP   4'h5
`define CMD_SUM_SECTOR   4'h6
`define CMD_SUM_ALL      4'h7

`define ERASE_MODE_BYTE   2'h0
`define ERASE_MODE_PAGE   2'h1
`define ERASE_MODE_SECTOR 2'h2
`define ERASE_MODE_CHIP   2'h3

`define BOOT_STATUS_RESET 8'h01
`define BOOT_VECTOR_4K    8'h0f
`define BOOT_VECTOR_8K    8'h1f
`define BOOT_VECTOR_16K   8'h3f
`define START_ADDR_LOW    8'h00
`define START_ADDR_USER   16'h0000

`define PAGE_BYTES        64
`define LOADER_BYTES      16'h0200
`define BOOT_ROM_FIRST    16'hff00
`define BOOT_ROM_LAST     16'hffef
`define BOOT_ROM_ENTRY    16'hff03

`define SUM_POLY          32'hedb88320
`define SUM_INIT          32'hffffffff

`define CLK_FREQ_MHZ      24'h000064
`define FLASH_OP_TIME_MS  24'h000002
`define FLASH_OP_CYCLES   (`FLASH_OP_TIME_MS * 24'h0003e8 * `CLK_FREQ_MHZ)

`endif

// file: page_buffer.v
// Page buffer storage with registered read port
`timescale 1ns/1ps
module page_buffer #(
  parameter WIDTH = 8,
  parameter DEPTH = 64,
  parameter AW    = 6
) (
  input  wire             clk_sys,
  input  wire             sys_rst,
  input  wire             wr_en,
  input  wire [AW-1:0]    wr_addr,
  input  wire [WIDTH-1:0] wr_data,
  input  wire [AW-1:0]    rd_addr,
  output reg  [WIDTH-1:0] rd_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];

  always @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      rd_data <= {WIDTH{1'b0}};
    end else begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule

// file: code_flash_controller_boot_select.v
// Code flash sequencer with page buffer, security, checksum and boot address selection
`timescale 1ns/1ps
`include "flash_ctrl_regs.vh"

// What this block does
// - Array in 4 or 8 sectors, 64-byte pages
// - 64-byte page buffer, 1..64 bytes per program
// - Chip, sector, page and byte erase
// - Any single byte erasable and programmable
// - Internal timing, every operation within 2 ms
// - Security setting per sector
// - Secured sector refuses code space data reads
// - 32-bit checksum over sector or whole array
// - Boot status zero starts at 0000H
// - Nonzero status starts at vector then 00H
// - Factory vector 0FH, 1FH or 3FH by size
// - Loader occupies top 512 bytes, stays erasable
// - Boot ROM mapped at FF00H to FFEFH
// - Control/status, data and two address registers
// - Forced loader pin acts as nonzero status
// - Eight security bits in one byte, one per sector
module code_flash_controller_boot_select #(
  parameter        SIZE_KB   = 8,
  parameter [23:0] OP_CYCLES = `FLASH_OP_CYCLES
) (
  input  wire        clk_sys,
  input  wire        sys_rst,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  input  wire        code_rd_valid,
  input  wire [15:0] code_rd_addr,
  input  wire        code_rd_data_access,
  output wire        code_rd_ready,
  output reg         code_rd_done,
  output reg  [7:0]  code_rd_data,
  output reg         code_rd_refused,
  output reg  [13:0] fl_addr,
  output reg         fl_re,
  input  wire [7:0]  fl_rdata,
  output reg  [7:0]  fl_wdata,
  output reg         fl_load,
  output reg         fl_prog,
  output reg         fl_erase,
  output reg  [1:0]  fl_erase_mode,
  output reg  [7:0]  rom_addr,
  output reg         rom_re,
  input  wire [7:0]  rom_rdata,
  input  wire        boot_force_pin,
  output reg  [15:0] boot_addr,
  output reg         boot_addr_valid
);
  localparam        SEC_SHIFT    = (SIZE_KB == 16) ? 11 : 10;
  localparam [15:0] ARRAY_BYTES  = (SIZE_KB == 4)  ? 16'h1000 :
                                   (SIZE_KB == 16) ? 16'h4000 : 16'h2000;
  localparam [13:0] SEC_SPAN     = (SIZE_KB == 16) ? 14'h07ff : 14'h03ff;
  localparam [13:0] ARRAY_LAST   = ARRAY_BYTES[13:0] - 14'h0001;
  localparam [15:0] LOADER_BASE  = ARRAY_BYTES - `LOADER_BYTES;
  localparam [7:0]  SEC_COUNT    = (SIZE_KB == 4) ? 8'h04 : 8'h08;
  localparam [23:0] OP_LAST      = OP_CYCLES - 24'h1;
  localparam [7:0]  VECTOR_RESET = (SIZE_KB == 4)  ? `BOOT_VECTOR_4K :
                                   (SIZE_KB == 16) ? `BOOT_VECTOR_16K : `BOOT_VECTOR_8K;

  localparam [4:0] S_IDLE  = 5'b00001;
  localparam [4:0] S_LOAD  = 5'b00010;
  localparam [4:0] S_PROG  = 5'b00100;
  localparam [4:0] S_ERASE = 5'b01000;
  localparam [4:0] S_SUM   = 5'b10000;

  reg  [4:0]  state;
  reg         wr_pend;
  reg  [7:0]  wr_addr;
  reg  [7:0]  addr_lo;
  reg  [7:0]  addr_hi;
  reg  [7:0]  data_last;
  reg  [7:0]  security;
  // Boot cells are flash, so they keep their value through sys_rst
  reg  [7:0]  boot_status = `BOOT_STATUS_RESET;
  reg  [7:0]  boot_vector = VECTOR_RESET;
  reg  [63:0] buf_mask;
  reg         flag_done;
  reg         flag_ignored;
  reg  [3:0]  last_op;
  reg  [31:0] sum_result;
  reg  [31:0] sum_acc;
  reg  [13:0] sum_ptr;
  reg  [13:0] sum_end;
  reg         sum_issued;
  reg         sum_v2;
  reg  [13:0] op_addr;
  reg  [23:0] timer;
  reg  [5:0]  idx;
  reg  [5:0]  idx_d;
  reg         ld_v;
  reg         ld_issued;
  reg         op_finish;
  reg         mask_clr;
  reg         rd_s1;
  reg         rd_s2;
  reg         rd_rom1;
  reg         rd_rom2;
  reg         rd_ref1;
  reg         rd_ref2;
  reg         force_meta;
  reg         force_sync;
  reg  [1:0]  boot_wait;
  reg  [31:0] rd_mux;
  wire [7:0]  buf_rdata;

  wire        st_idle   = state[0];
  wire        ahb_go    = hsel & hready & htrans[1];
  wire        wr_now    = wr_pend & hready;
  wire        cmd_wr    = wr_now & (wr_addr == `REG_CTRL_STATUS);
  wire [3:0]  cmd       = hwdata[`CTL_CMD_LSB+3:`CTL_CMD_LSB];
  wire        cmd_known = (cmd != `CMD_NONE) & (cmd <= `CMD_SUM_ALL);
  wire        cmd_start = cmd_wr & cmd_known & st_idle;
  wire        cmd_block = cmd_wr & cmd_known & ~st_idle;
  wire        data_wr   = wr_now & (wr_addr == `REG_DATA) & st_idle;
  wire [13:0] cur_addr  = {addr_hi[5:0], addr_lo};
  wire        rd_rom    = (code_rd_addr >= `BOOT_ROM_FIRST) &
                          (code_rd_addr <= `BOOT_ROM_LAST);
  wire [2:0]  rd_sector = code_rd_addr[SEC_SHIFT+2:SEC_SHIFT];
  wire        rd_secure = code_rd_data_access & ~rd_rom & security[rd_sector];
  wire        rd_accept = code_rd_valid & code_rd_ready;

  assign hreadyout     = 1'b1;
  assign hresp         = 1'b0;
  // Commands win the array over core reads in the same cycle
  assign code_rd_ready = st_idle & ~cmd_start;

  function [31:0] sum_byte;
    input [31:0] c;
    input [7:0]  d;
    integer      k;
    reg   [31:0] r;
    begin
      r = c ^ {24'h000000, d};
      for (k = 0; k < 8; k = k + 1) begin
        r = r[0] ? ((r >> 1) ^ `SUM_POLY) : (r >> 1);
      end
      sum_byte = r;
    end
  endfunction

  page_buffer #(
    .WIDTH (8),
    .DEPTH (`PAGE_BYTES),
    .AW    (6)
  ) u_page_buffer (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .wr_en   (data_wr),
    .wr_addr (addr_lo[5:0]),
    .wr_data (hwdata[7:0]),
    .rd_addr (idx),
    .rd_data (buf_rdata)
  );

  always @* begin
    case (haddr[7:0])
      `REG_CTRL_STATUS: rd_mux = {24'h000000, last_op, 1'b0, flag_ignored, flag_done, ~st_idle};
      `REG_DATA:        rd_mux = {24'h000000, data_last};
      `REG_ADDR_LO:     rd_mux = {24'h000000, addr_lo};
      `REG_ADDR_HI:     rd_mux = {24'h000000, addr_hi};
      `REG_SECURITY:    rd_mux = {24'h000000, security};
      `REG_BOOT:        rd_mux = {16'h0000, boot_vector, boot_status};
      `REG_CHECKSUM:    rd_mux = sum_result;
      `REG_INFO:        rd_mux = {8'h00, SEC_COUNT, LOADER_BASE};
      default:          rd_mux = 32'h00000000;
    endcase
  end

  // Reads sample in the address phase, writes land in the data phase
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata  <= 32'h00000000;
    end else if (hready) begin
      wr_pend <= ahb_go & hwrite;
      wr_addr <= haddr[7:0];
      if (ahb_go & ~hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      addr_lo      <= 8'h00;
      addr_hi      <= 8'h00;
      data_last    <= 8'h00;
      security     <= 8'h00;
      buf_mask     <= 64'h0;
      flag_done    <= 1'b0;
      flag_ignored <= 1'b0;
      last_op      <= `CMD_NONE;
    end else begin
      if (wr_now & (wr_addr == `REG_ADDR_LO)) begin
        addr_lo <= hwdata[7:0];
      end else if (data_wr) begin
        // Offset wraps inside the page so a burst of loads stays in one page
        addr_lo <= {addr_lo[7:6], addr_lo[5:0] + 6'h01};
      end
      if (wr_now & (wr_addr == `REG_ADDR_HI)) begin
        addr_hi <= hwdata[7:0];
      end
      if (data_wr) begin
        data_last <= hwdata[7:0];
      end
      if (wr_now & (wr_addr == `REG_SECURITY)) begin
        security <= hwdata[7:0];
      end
      if (wr_now & (wr_addr == `REG_BOOT)) begin
        boot_status <= hwdata[7:0];
        boot_vector <= hwdata[15:8];
      end
      if (mask_clr) begin
        buf_mask <= 64'h0;
      end else if (data_wr) begin
        buf_mask[addr_lo[5:0]] <= 1'b1;
      end
      // Hardware set wins over a software clear in the same cycle
      if (op_finish) begin
        flag_done <= 1'b1;
      end else if (cmd_wr & hwdata[`CTL_DONE_CLR_BIT]) begin
        flag_done <= 1'b0;
      end
      if (cmd_block) begin
        flag_ignored <= 1'b1;
      end else if (cmd_wr & hwdata[`CTL_IGN_CLR_BIT]) begin
        flag_ignored <= 1'b0;
      end
      if (cmd_start) begin
        last_op <= cmd;
      end
    end
  end

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      state           <= S_IDLE;
      fl_addr         <= 14'h0000;
      fl_re           <= 1'b0;
      fl_wdata        <= 8'h00;
      fl_load         <= 1'b0;
      fl_prog         <= 1'b0;
      fl_erase        <= 1'b0;
      fl_erase_mode   <= `ERASE_MODE_BYTE;
      rom_addr        <= 8'h00;
      rom_re          <= 1'b0;
      op_addr         <= 14'h0000;
      timer           <= 24'h000000;
      idx             <= 6'h00;
      idx_d           <= 6'h00;
      ld_v            <= 1'b0;
      ld_issued       <= 1'b0;
      op_finish       <= 1'b0;
      mask_clr        <= 1'b0;
      sum_acc         <= `SUM_INIT;
      sum_result      <= 32'h00000000;
      sum_ptr         <= 14'h0000;
      sum_end         <= 14'h0000;
      sum_issued      <= 1'b0;
      sum_v2          <= 1'b0;
      rd_s1           <= 1'b0;
      rd_s2           <= 1'b0;
      rd_rom1         <= 1'b0;
      rd_rom2         <= 1'b0;
      rd_ref1         <= 1'b0;
      rd_ref2         <= 1'b0;
      code_rd_done    <= 1'b0;
      code_rd_data    <= 8'h00;
      code_rd_refused <= 1'b0;
    end else begin
      op_finish <= 1'b0;
      mask_clr  <= 1'b0;
      fl_re     <= 1'b0;
      fl_load   <= 1'b0;
      rom_re    <= 1'b0;
      sum_v2    <= fl_re & state[4];
      rd_s1     <= rd_accept;
      rd_rom1   <= rd_rom;
      rd_ref1   <= rd_secure;
      rd_s2     <= rd_s1;
      rd_rom2   <= rd_rom1;
      rd_ref2   <= rd_ref1;
      code_rd_done <= rd_s2;
      if (rd_s2) begin
        code_rd_refused <= rd_ref2;
        code_rd_data    <= rd_ref2 ? 8'h00 : (rd_rom2 ? rom_rdata : fl_rdata);
      end
      case (state)
        S_IDLE: begin
          if (rd_accept) begin
            if (rd_rom) begin
              rom_re   <= 1'b1;
              rom_addr <= code_rd_addr[7:0];
            end else if (!rd_secure) begin
              fl_re   <= 1'b1;
              fl_addr <= code_rd_addr[13:0];
            end
          end
          if (cmd_start) begin
            op_addr <= cur_addr;
            timer   <= OP_LAST;
            case (cmd)
              `CMD_COMMIT: begin
                idx       <= 6'h00;
                ld_v      <= 1'b0;
                ld_issued <= 1'b0;
                if (buf_mask == 64'h0) begin
                  op_finish <= 1'b1;
                end else begin
                  state <= S_LOAD;
                end
              end
              `CMD_SUM_SECTOR, `CMD_SUM_ALL: begin
                sum_acc    <= `SUM_INIT;
                sum_issued <= 1'b0;
                sum_ptr    <= (cmd == `CMD_SUM_ALL) ? 14'h0000 : (cur_addr & ~SEC_SPAN);
                sum_end    <= (cmd == `CMD_SUM_ALL) ? ARRAY_LAST : (cur_addr | SEC_SPAN);
                state      <= S_SUM;
              end
              default: begin
                // Loader area gets no special guard, it erases like any code
                fl_erase <= 1'b1;
                state    <= S_ERASE;
                case (cmd)
                  `CMD_ERASE_BYTE: begin
                    fl_erase_mode <= `ERASE_MODE_BYTE;
                    fl_addr       <= cur_addr;
                  end
                  `CMD_ERASE_PAGE: begin
                    fl_erase_mode <= `ERASE_MODE_PAGE;
                    fl_addr       <= {cur_addr[13:6], 6'h00};
                  end
                  `CMD_ERASE_SECTOR: begin
                    fl_erase_mode <= `ERASE_MODE_SECTOR;
                    fl_addr       <= cur_addr & ~SEC_SPAN;
                  end
                  default: begin
                    fl_erase_mode <= `ERASE_MODE_CHIP;
                    fl_addr       <= 14'h0000;
                  end
                endcase
              end
            endcase
          end
        end
        S_LOAD: begin
          // Buffer read is registered, so the latch step trails the index by one
          ld_v  <= ~ld_issued;
          idx_d <= idx;
          if (!ld_issued) begin
            idx <= idx + 6'h01;
            if (idx == 6'h3f) begin
              ld_issued <= 1'b1;
            end
          end
          if (ld_v & buf_mask[idx_d]) begin
            fl_load  <= 1'b1;
            fl_addr  <= {op_addr[13:6], idx_d};
            fl_wdata <= buf_rdata;
          end
          if (ld_issued & ~ld_v) begin
            fl_prog <= 1'b1;
            timer   <= OP_LAST;
            state   <= S_PROG;
          end
        end
        S_PROG: begin
          timer <= timer - 24'h000001;
          if (timer == 24'h000000) begin
            fl_prog   <= 1'b0;
            mask_clr  <= 1'b1;
            op_finish <= 1'b1;
            state     <= S_IDLE;
          end
        end
        S_ERASE: begin
          timer <= timer - 24'h000001;
          if (timer == 24'h000000) begin
            fl_erase  <= 1'b0;
            op_finish <= 1'b1;
            state     <= S_IDLE;
          end
        end
        S_SUM: begin
          if (!sum_issued) begin
            fl_re   <= 1'b1;
            fl_addr <= sum_ptr;
            if (sum_ptr == sum_end) begin
              sum_issued <= 1'b1;
            end else begin
              sum_ptr <= sum_ptr + 14'h0001;
            end
          end
          if (sum_v2) begin
            sum_acc <= sum_byte(sum_acc, fl_rdata);
          end
          if (sum_issued & ~fl_re & ~sum_v2) begin
            sum_result <= ~sum_acc;
            op_finish  <= 1'b1;
            state      <= S_IDLE;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // Strap is sampled only after the synchroniser has settled past reset
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      force_meta      <= 1'b0;
      force_sync      <= 1'b0;
      boot_wait       <= 2'h0;
      boot_addr       <= `START_ADDR_USER;
      boot_addr_valid <= 1'b0;
    end else begin
      force_meta <= boot_force_pin;
      force_sync <= force_meta;
      if (boot_wait != 2'h3) begin
        boot_wait <= boot_wait + 2'h1;
      end
      if (boot_wait == 2'h2) begin
        boot_addr_valid <= 1'b1;
        if ((boot_status != 8'h00) | force_sync) begin
          boot_addr <= {boot_vector, `START_ADDR_LOW};
        end else begin
          boot_addr <= `START_ADDR_USER;
        end
      end
    end
  end
endmodule

// file: flash_ctrl_chk.sv
// Port-level concurrent checks for the code flash controller
`timescale 1ns/1ps
module flash_ctrl_chk #(
  parameter [23:0] OP_CYCLES = 24'd8
) (
  input logic        clk_sys,
  input logic        sys_rst,
  input logic        hreadyout,
  input logic        hresp,
  input logic        code_rd_valid,
  input logic [15:0] code_rd_addr,
  input logic        code_rd_data_access,
  input logic        code_rd_ready,
  input logic        code_rd_done,
  input logic [7:0]  code_rd_data,
  input logic        code_rd_refused,
  input logic [13:0] fl_addr,
  input logic        fl_re,
  input logic        fl_prog,
  input logic        fl_erase,
  input logic [7:0]  rom_addr,
  input logic        rom_re,
  input logic [15:0] boot_addr,
  input logic        boot_addr_valid
);
  logic [23:0] prog_cnt;
  logic [23:0] erase_cnt;
  logic        take;
  logic        in_rom;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  assign take   = code_rd_valid && code_rd_ready;
  assign in_rom = code_rd_addr >= 16'hff00 && code_rd_addr <= 16'hffef;
  // High-time counters, read at the falling edge of each strobe
  always @(posedge clk_sys) begin
    prog_cnt  <= (sys_rst || !fl_prog) ? 24'h0 : prog_cnt + 24'h1;
    erase_cnt <= (sys_rst || !fl_erase) ? 24'h0 : erase_cnt + 24'h1;
  end
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus slave not ready or not OKAY");
  a_prog_time: assert property ($fell(fl_prog) |-> prog_cnt == OP_CYCLES)
    else $error("program strobe length wrong");
  a_erase_time: assert property ($fell(fl_erase) |-> erase_cnt == OP_CYCLES)
    else $error("erase strobe length wrong");
  a_read_latency: assert property (take |-> ##3 code_rd_done)
    else $error("code read answer late");
  a_refused_zero: assert property (code_rd_done && code_rd_refused |-> code_rd_data == 8'h00)
    else $error("refused read leaks data");
  a_fetch_array: assert property (take && !code_rd_data_access && !in_rom |=>
    fl_re && {2'b00, fl_addr} == ($past(code_rd_addr) & 16'h3fff))
    else $error("fetch did not reach the array");
  a_rom_map: assert property (take && in_rom |=> rom_re && !fl_re &&
    {8'hff, rom_addr} == $past(code_rd_addr))
    else $error("boot ROM window not mapped");
  a_busy_blocks: assert property ((fl_prog || fl_erase) |-> !code_rd_ready)
    else $error("reads accepted while busy");
  a_one_op: assert property (!(fl_prog && fl_erase))
    else $error("program and erase overlap");
  a_boot_low: assert property (boot_addr_valid |-> boot_addr[7:0] == 8'h00 &&
    (!$past(boot_addr_valid) || $stable(boot_addr)))
    else $error("boot address low byte or stability wrong");
  a_boot_delay: assert property ($fell(sys_rst) |-> !boot_addr_valid ##[2:3] boot_addr_valid)
    else $error("boot address not ready after reset");
  c_prog: cover property ($fell(fl_prog));
  c_erase: cover property ($fell(fl_erase));
  c_refused: cover property (code_rd_done && code_rd_refused);
  c_rom: cover property (rom_re);
endmodule

bind code_flash_controller_boot_select flash_ctrl_chk #(.OP_CYCLES(OP_CYCLES)) chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .hreadyout(hreadyout), .hresp(hresp),
  .code_rd_valid(code_rd_valid), .code_rd_addr(code_rd_addr),
  .code_rd_data_access(code_rd_data_access), .code_rd_ready(code_rd_ready),
  .code_rd_done(code_rd_done), .code_rd_data(code_rd_data), .code_rd_refused(code_rd_refused),
  .fl_addr(fl_addr), .fl_re(fl_re), .fl_prog(fl_prog), .fl_erase(fl_erase),
  .rom_addr(rom_addr), .rom_re(rom_re), .boot_addr(boot_addr), .boot_addr_valid(boot_addr_valid));

// file: flash_array_model.sv
// Behavioural flash array and boot ROM on the far side of the controller
`timescale 1ns/1ps
module flash_array_model #(
  parameter SECT_SH = 10
) (
  input  wire logic        clk_sys,
  input  wire logic [13:0] fl_addr,
  input  wire logic        fl_re,
  input  wire logic [7:0]  fl_wdata,
  input  wire logic        fl_load,
  input  wire logic        fl_prog,
  input  wire logic        fl_erase,
  input  wire logic [1:0]  fl_erase_mode,
  input  wire logic [7:0]  rom_addr,
  input  wire logic        rom_re,
  output logic      [7:0]  fl_rdata,
  output logic      [7:0]  rom_rdata
);
  logic [7:0]  mem [0:16383];
  logic [7:0]  latch [0:63];
  logic [63:0] mask = 64'h0;
  logic [7:0]  page_sel = 8'h0;
  logic        prog_q = 1'b0;
  logic        erase_q = 1'b0;
  int          sh;
  initial begin
    fl_rdata = 8'h00;
    rom_rdata = 8'h00;
    for (int i = 0; i < 16384; i++) mem[i] = i[7:0] ^ 8'h5a;
  end
  always @(posedge clk_sys) begin
    // Answer stands one cycle, then inverts so a late capture never matches
    fl_rdata  <= fl_re ? mem[fl_addr] : ~fl_rdata;
    rom_rdata <= rom_re ? ~rom_addr : ~rom_rdata;
    prog_q  <= fl_prog;
    erase_q <= fl_erase;
    if (fl_load) begin
      latch[fl_addr[5:0]] <= fl_wdata;
      mask[fl_addr[5:0]] <= 1'b1;
      page_sel <= fl_addr[13:6];
    end
    // Programming only clears bits, as real cells do
    if (fl_prog && !prog_q) begin
      for (int i = 0; i < 64; i++)
        if (mask[i]) mem[{page_sel, i[5:0]}] = mem[{page_sel, i[5:0]}] & latch[i];
      mask <= 64'h0;
    end
    if (fl_erase && !erase_q) begin
      sh = (fl_erase_mode == 2'h1) ? 6 : (fl_erase_mode == 2'h2) ? SECT_SH : 0;
      for (int i = 0; i < 16384; i++)
        if (fl_erase_mode == 2'h3 || (i >> sh) == (fl_addr >> sh)) mem[i] = 8'hff;
    end
  end
endmodule

// file: testbench.sv
// Self-checking bench: register bus, code reads, erase, checksum, commit, boot
`timescale 1ns/1ps
`include "flash_ctrl_regs.vh"
module testbench;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        code_rd_valid = 1'b0;
  logic [15:0] code_rd_addr = 16'h0;
  logic        code_rd_data_access = 1'b0;
  logic        boot_force_pin = 1'b0;
  wire         hreadyout, hresp, code_rd_ready, code_rd_done, code_rd_refused;
  wire         fl_re, fl_load, fl_prog, fl_erase, rom_re, boot_addr_valid;
  wire  [31:0] hrdata;
  wire  [13:0] fl_addr;
  wire  [7:0]  code_rd_data, fl_rdata, fl_wdata, rom_addr, rom_rdata;
  wire  [1:0]  fl_erase_mode;
  wire  [15:0] boot_addr;
  int          num_errors = 0;
  int          checks = 0;
  int          loads = 0;
  logic [1:0]  emode = 2'h0;
  logic [31:0] rdat, st;
  logic [15:0] ea [4] = '{16'h0101, 16'h0141, 16'h0800, 16'h1fff};
  logic [15:0] pa [4] = '{16'h0102, 16'h0180, 16'h0c00, 16'h0000};
  logic [8:0]  pe [4] = '{9'h058, 9'h0da, 9'h05a, 9'h0ff};
  logic [15:0] sa [5] = '{16'h0400, 16'h07ff, 16'h0400, 16'h0011, 16'hff03};
  logic        sc [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
  logic [8:0]  se [5] = '{9'h100, 9'h100, 9'h05a, 9'h04b, 9'h0fc};

  code_flash_controller_boot_select #(.SIZE_KB(8), .OP_CYCLES(24'd8)) uut (
    .*, .hsize(3'h2), .hready(hreadyout));
  flash_array_model array (.*);

  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (fl_load === 1'b1) loads <= loads + 1;
    if (fl_erase === 1'b1) emode <= fl_erase_mode;
  end

  task automatic finish_test();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic hang();
    num_errors++;
    $display("[FAIL] %0t wait ran out", $time);
    finish_test();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus_wait();
    int n;
    n = 0;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) hang();
      @(posedge clk_sys);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    bus_wait();
    htrans <= 2'h0;
    hwdata <= d;
    bus_wait();
    rdat = hrdata;
    hsel <= 1'b0;
  endtask
  // Waits for done, keeps the status word, then clears both flags
  task automatic op(input logic [3:0] c);
    int n;
    n = 0;
    bus(1'b1, `REG_CTRL_STATUS, {28'h0, c});
    rdat = 32'h0;
    while (rdat[1] !== 1'b1) begin
      n++;
      if (n > 4000) hang();
      bus(1'b0, `REG_CTRL_STATUS, 32'h0);
    end
    st = rdat;
    bus(1'b1, `REG_CTRL_STATUS, 32'h300);
  endtask
  task automatic cread(input logic [15:0] a, input logic acc, input logic [8:0] exp);
    int n;
    n = 0;
    @(posedge clk_sys);
    code_rd_valid <= 1'b1;
    code_rd_addr <= a;
    code_rd_data_access <= acc;
    do begin
      @(posedge clk_sys);
      n++;
    end while (code_rd_ready !== 1'b1 && n < 50);
    code_rd_valid <= 1'b0;
    while (code_rd_done !== 1'b1 && n < 60) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 60) hang();
    chk({23'h0, code_rd_refused, code_rd_data}, {23'h0, exp});
  endtask
  task automatic sys_reset();
    int n;
    n = 0;
    sys_rst <= 1'b1;
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    while (boot_addr_valid !== 1'b1) begin
      @(posedge clk_sys);
      n++;
      if (n > 10) hang();
    end
  endtask
  function automatic logic [31:0] crc_ff(input int n);
    logic [31:0] c;
    c = `SUM_INIT;
    for (int i = 0; i < n * 8; i++) c = (c >> 1) ^ (c[0] ? 32'h0 : `SUM_POLY);
    return ~c;
  endfunction
  task automatic set_addr(input logic [15:0] a);
    bus(1'b1, `REG_ADDR_LO, {24'h0, a[7:0]});
    bus(1'b1, `REG_ADDR_HI, {24'h0, a[15:8]});
  endtask

  initial begin
    sys_reset();
    bus(1'b0, `REG_BOOT, 32'h0);
    chk(rdat, 32'h0000_1f01);
    chk({16'h0, boot_addr}, 32'h0000_1f00);
    bus(1'b0, `REG_INFO, 32'h0);
    chk(rdat, 32'h0008_1e00);
    bus(1'b0, 8'h20, 32'h0);
    chk(rdat, 32'h0);
    bus(1'b1, `REG_BOOT, 32'h0000_1f00);
    bus(1'b0, `REG_BOOT, 32'h0);
    chk(rdat, 32'h0000_1f00);
    $display("test reset values done");
    bus(1'b1, `REG_SECURITY, 32'h2);
    for (int i = 0; i < 5; i++) cread(sa[i], sc[i], se[i]);
    bus(1'b1, `REG_SECURITY, 32'h0);
    $display("test security done");
    for (int m = 0; m < 4; m++) begin
      set_addr(ea[m]);
      op(4'(m + 2));
      chk({24'h0, st[7:0]}, {24'h0, 4'(m + 2), 4'h2});
      chk({30'h0, emode}, m);
      cread(ea[m], 1'b1, 9'h0ff);
      cread(pa[m], 1'b1, pe[m]);
    end
    $display("test erase done");
    set_addr(16'h0000);
    op(`CMD_SUM_SECTOR);
    bus(1'b0, `REG_CHECKSUM, 32'h0);
    chk(rdat, crc_ff(1024));
    op(`CMD_SUM_ALL);
    bus(1'b0, `REG_CHECKSUM, 32'h0);
    chk(rdat, crc_ff(8192));
    $display("test checksum done");
    set_addr(16'h0043);
    bus(1'b1, `REG_DATA, 32'h12);
    bus(1'b1, `REG_DATA, 32'h34);
    bus(1'b1, `REG_CTRL_STATUS, {28'h0, `CMD_COMMIT});
    op(`CMD_ERASE_BYTE);
    chk({24'h0, st[7:0]}, 32'h16);
    chk(loads, 2);
    cread(16'h0043, 1'b1, 9'h012);
    cread(16'h0044, 1'b1, 9'h034);
    cread(16'h0045, 1'b1, 9'h0ff);
    $display("test commit done");
    sys_reset();
    chk({16'h0, boot_addr}, 32'h0);
    boot_force_pin <= 1'b1;
    sys_reset();
    chk({16'h0, boot_addr}, 32'h0000_1f00);
    $display("test boot select done");
    finish_test();
  end
endmodule
